// File: src/nvs_spi_pkg.sv
package nvs_spi_pkg;

   // Clock and delay figures; cycle counts derive from them.
   localparam int CLK_PERIOD_NS = 10;
   localparam int POWERUP_RECALL_TIME_NS = 40000;
   localparam int WRITE_FINISH_DELAY_NS = 25000;
   localparam int RECALL_CYCLES =
      (POWERUP_RECALL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FINISH_CYCLES =
      (WRITE_FINISH_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Array geometry and write queue depth.
   localparam int ADDR_BITS = 17;
   localparam int FIFO_DEPTH = 16;
   localparam logic [1:0] LAST_ADDR_BYTE = 2'h2;

   // Instruction opcodes.
   localparam logic [7:0] OP_SET_WL = 8'h06;
   localparam logic [7:0] OP_CLR_WL = 8'h04;
   localparam logic [7:0] OP_STATUS_R = 8'h05;
   localparam logic [7:0] OP_STATUS_W = 8'h01;
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_WRITE = 8'h02;
   localparam logic [7:0] OP_STORE = 8'h3c;
   localparam logic [7:0] OP_RECALL = 8'h60;
   localparam logic [7:0] OP_AUTO_ON = 8'h59;
   localparam logic [7:0] OP_AUTO_OFF = 8'h19;

   // Status register field positions.
   localparam int ST_RDY = 0;
   localparam int ST_WEN = 1;
   localparam int ST_BP0 = 2;
   localparam int ST_BP1 = 3;
   localparam int ST_DC_LO = 4;
   localparam int ST_WP_PIN_ENABLE_BIT = 7;

   // Values after reset.
   localparam logic WEN_RST = 1'b0;
   localparam logic AUTOSAVE_RST = 1'b1;
   localparam logic [2:0] DC_RST = 3'h0;

   typedef enum logic [3:0] {
      PH_IDLE, PH_OPCODE, PH_ADDR, PH_WDATA, PH_RDATA,
      PH_STATUS_R, PH_STATUS_W, PH_IGNORE, PH_DONE
   } phase_t;

   typedef enum logic [1:0] {PW_RECALL, PW_RUN, PW_DRAIN, PW_OFF} pw_t;

endpackage

// File: src/nvs_fifo_if.sv
`timescale 1ns/100ps
interface nvs_fifo_if #(parameter int W = 8);
   logic push_valid;
   logic push_ready;
   logic [W-1:0] push_data;
   logic pop_valid;
   logic pop_ready;
   logic [W-1:0] pop_data;

   // Filling side sees push_ready; draining side drives pop_ready.
   modport sink(input push_valid, input push_data, output push_ready);
   modport source(output pop_valid, output pop_data, input pop_ready);
endinterface

// File: src/nvs_write_fifo.sv
`timescale 1ns/100ps
module nvs_write_fifo #(
   parameter int WIDTH = 25,
   parameter int DEPTH = 16
) (
   input wire logic clk_i,
   input wire logic reset_i,
   nvs_fifo_if.sink fill,
   nvs_fifo_if.source drain
);
   localparam int PW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0] wr_ptr;
      logic [PW-1:0] rd_ptr;
      logic [PW:0] count;
   } fifo_t;

   fifo_t st_reg;
   fifo_t st_next;
   logic do_push;
   logic do_pop;

   // Full and empty come straight from the occupancy count.
   assign fill.push_ready = st_reg.count != (PW+1)'(DEPTH);
   assign drain.pop_valid = st_reg.count != '0;
   assign drain.pop_data = st_reg.mem[st_reg.rd_ptr];
   assign do_push = fill.push_valid && fill.push_ready;
   assign do_pop = drain.pop_valid && drain.pop_ready;

   // Pointers wrap at DEPTH; depth must be a power of two.
   always_comb begin
      st_next = st_reg;
      if (do_push) begin
         st_next.mem[st_reg.wr_ptr] = fill.push_data;
         st_next.wr_ptr = st_reg.wr_ptr + 1'b1;
      end
      if (do_pop) begin
         st_next.rd_ptr = st_reg.rd_ptr + 1'b1;
      end
      if (do_push && !do_pop) begin
         st_next.count = st_reg.count + 1'b1;
      end else if (do_pop && !do_push) begin
         st_next.count = st_reg.count - 1'b1;
      end
   end

   // Storage state register.
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
endmodule

// File: src/nvsram_spi_slave_frontend.sv
`timescale 1ns/100ps
module nvsram_spi_slave_frontend
   import nvs_spi_pkg::*;
#(
   parameter int RECALL_CNT = RECALL_CYCLES,
   parameter int FINISH_CNT = FINISH_CYCLES,
   parameter int FIFO_WORDS = FIFO_DEPTH
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic cs_n_i,
   input wire logic sck_i,
   input wire logic si_i,
   output logic so_o,
   output logic so_oe_o,
   input wire logic hw_store_busy_pin_i,
   output logic hw_store_busy_pin_o,
   output logic hw_store_busy_pin_oe_o,
   input wire logic power_good_i,
   output logic [ADDR_BITS-1:0] mem_addr_o,
   output logic mem_rd_o,
   input wire logic [7:0] mem_rdata_i,
   output logic wr_valid_o,
   output logic [ADDR_BITS-1:0] wr_addr_o,
   output logic [7:0] wr_data_o,
   input wire logic wr_ready_i,
   output logic store_req_o,
   output logic recall_req_o,
   input wire logic nv_busy_i,
   input wire logic [2:0] nv_prot_i,
   output logic [7:0] status_o,
   output logic auto_save_en_o,
   output logic spi_mode3_o,
   output logic standby_o,
   output logic write_overrun_o
);
   localparam int WW = ADDR_BITS + 8;

   typedef struct packed {
      logic cs1, cs2, cs3;
      logic sck1, sck2, sck3;
      logic si1, si2;
      logic pg1, pg2;
      logic hsb1, hsb2, hsb3;
      pw_t pw;
      logic [15:0] timer;
      phase_t phase;
      logic sel;
      logic mode3;
      logic [2:0] bit_cnt;
      logic [1:0] byte_cnt;
      logic [7:0] rx;
      logic [7:0] opc;
      logic rd_mode;
      logic consume;
      logic [ADDR_BITS-1:0] addr;
      logic mem_rd;
      logic rd_pend;
      logic [7:0] rdata;
      logic [7:0] tx;
      logic [2:0] out_cnt;
      logic out_on;
      logic so;
      logic wpend;
      logic [WW-1:0] wdata;
      logic overrun;
      logic wen;
      logic [2:0] prot;
      logic [2:0] dc;
      logic autosave;
      logic dirty;
      logic store_req;
      logic recall_req;
      logic [1:0] rc_st;
   } state_t;

   localparam state_t ST_RST = '{pw: PW_RECALL,
      timer: 16'(RECALL_CNT), phase: PH_IDLE, wen: WEN_RST,
      dc: DC_RST, autosave: AUTOSAVE_RST, default: '0};

   state_t st;
   state_t nx;
   logic busy;
   logic cs_fall, cs_rise, sck_rise, sck_fall, hsb_fall;
   logic [7:0] rx_byte;
   logic [7:0] status;

   nvs_fifo_if #(.W(WW)) wq();

   nvs_write_fifo #(.WIDTH(WW), .DEPTH(FIFO_WORDS)) u_fifo (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .fill(wq.sink),
      .drain(wq.source)
   );

   // Edges are taken from the second and third synchroniser stages.
   assign cs_fall = st.cs3 && !st.cs2;
   assign cs_rise = !st.cs3 && st.cs2;
   assign sck_rise = !st.sck3 && st.sck2;
   assign sck_fall = st.sck3 && !st.sck2;
   assign hsb_fall = st.hsb3 && !st.hsb2;
   assign rx_byte = {st.rx[6:0], st.si2};
   assign busy = (st.pw == PW_RECALL) || nv_busy_i || st.store_req
      || st.recall_req || (st.rc_st != 2'h0);
   assign status = {st.prot[2], st.dc, st.prot[1], st.prot[0],
      st.wen, busy};

   always_comb begin
      nx = st;
      nx.cs1 = cs_n_i;
      nx.cs2 = st.cs1;
      nx.cs3 = st.cs2;
      nx.sck1 = sck_i;
      nx.sck2 = st.sck1;
      nx.sck3 = st.sck2;
      nx.si1 = si_i;
      nx.si2 = st.si1;
      nx.pg1 = power_good_i;
      nx.pg2 = st.pg1;
      nx.hsb1 = hw_store_busy_pin_i;
      nx.hsb2 = st.hsb1;
      nx.hsb3 = st.hsb2;
      nx.mem_rd = 1'b0;
      nx.store_req = 1'b0;
      nx.recall_req = 1'b0;
      nx.rd_pend = st.mem_rd;
      if (st.rd_pend) begin
         nx.rdata = mem_rdata_i;
      end
      // A queued write leaves as soon as the queue accepts it.
      if (wq.push_ready) begin
         nx.wpend = 1'b0;
      end
      unique case (st.rc_st)
         2'h1: if (nv_busy_i) nx.rc_st = 2'h2;
         2'h2: begin
            if (!nv_busy_i) begin
               nx.rc_st = 2'h0;
               nx.prot = nv_prot_i;
               nx.dirty = 1'b0;
            end
         end
         default: ;
      endcase
      // An outside low on the busy pin asks for a conditional store.
      if (hsb_fall && !busy && st.dirty && st.pw == PW_RUN) begin
         nx.store_req = 1'b1;
      end
      unique case (st.pw)
         PW_RECALL: begin
            nx.recall_req = st.timer == 16'(RECALL_CNT);
            if (st.timer == 16'h0) begin
               nx.pw = PW_RUN;
               nx.prot = nv_prot_i;
               nx.dirty = 1'b0;
            end else begin
               nx.timer = st.timer - 16'h1;
            end
         end
         PW_RUN: begin
            if (!st.pg2) begin
               nx.sel = 1'b0;
               nx.phase = PH_IDLE;
               nx.out_on = 1'b0;
               nx.timer = 16'(FINISH_CNT);
               nx.pw = PW_DRAIN;
            end
         end
         PW_DRAIN: begin
            if (st.timer == 16'h0) begin
               nx.pw = PW_OFF;
               nx.store_req = st.autosave && st.dirty;
            end else begin
               nx.timer = st.timer - 16'h1;
            end
         end
         PW_OFF: begin
            if (st.pg2) begin
               nx.pw = PW_RECALL;
               nx.timer = 16'(RECALL_CNT);
            end
         end
      endcase
      // select only on a falling edge
      // A select seen as the supply drops must not undo the deselect.
      if (cs_fall && st.pw == PW_RUN && st.pg2) begin
         nx.sel = 1'b1;
         nx.mode3 = st.sck2;
         nx.phase = PH_OPCODE;
         nx.bit_cnt = 3'h0;
         nx.byte_cnt = 2'h0;
         nx.out_cnt = 3'h0;
         nx.out_on = 1'b0;
         nx.consume = 1'b0;
         nx.overrun = 1'b0;
      end else if (cs_rise && st.sel) begin
         nx.sel = 1'b0;
         nx.phase = PH_IDLE;
         nx.out_on = 1'b0;
         if (st.phase == PH_DONE) begin
            unique case (st.opc)
               OP_SET_WL: nx.wen = 1'b1;
               OP_CLR_WL: nx.wen = 1'b0;
               OP_STORE: nx.store_req = 1'b1;
               OP_RECALL: begin
                  nx.recall_req = 1'b1;
                  nx.rc_st = 2'h1;
               end
               OP_AUTO_ON: nx.autosave = 1'b1;
               OP_AUTO_OFF: nx.autosave = 1'b0;
               default: ;
            endcase
         end
         if (st.consume) begin
            nx.wen = 1'b0;
         end
      end else if (st.sel && sck_rise && st.pg2) begin
         nx.rx = rx_byte;
         nx.bit_cnt = st.bit_cnt + 3'h1;
         if (st.bit_cnt == 3'h7) begin
            unique case (st.phase)
               PH_OPCODE: begin
                  nx.opc = rx_byte;
                  unique case (rx_byte)
                     OP_SET_WL, OP_CLR_WL: nx.phase = PH_DONE;
                     OP_STATUS_R: nx.phase = PH_STATUS_R;
                     OP_STATUS_W: begin
                        nx.phase = st.wen ? PH_STATUS_W : PH_IGNORE;
                        nx.consume = st.wen;
                     end
                     OP_READ: begin
                        nx.phase = busy ? PH_IGNORE : PH_ADDR;
                        nx.rd_mode = 1'b1;
                     end
                     OP_WRITE: begin
                        nx.phase = (st.wen && !busy) ? PH_ADDR : PH_IGNORE;
                        nx.rd_mode = 1'b0;
                        nx.consume = st.wen && !busy;
                     end
                     OP_STORE, OP_RECALL: begin
                        nx.phase = (st.wen && !busy) ? PH_DONE : PH_IGNORE;
                        nx.consume = st.wen && !busy;
                     end
                     OP_AUTO_ON, OP_AUTO_OFF: begin
                        nx.phase = st.wen ? PH_DONE : PH_IGNORE;
                        nx.consume = st.wen;
                     end
                     default: nx.phase = PH_IGNORE;
                  endcase
               end
               // 24 bits in, top seven fall off
               PH_ADDR: begin
                  nx.addr = {st.addr[8:0], rx_byte};
                  nx.byte_cnt = st.byte_cnt + 2'h1;
                  if (st.byte_cnt == LAST_ADDR_BYTE) begin
                     nx.phase = st.rd_mode ? PH_RDATA : PH_WDATA;
                     nx.mem_rd = st.rd_mode;
                  end
               end
               PH_WDATA: begin
                  if (st.wpend && !wq.push_ready) begin
                     nx.overrun = 1'b1;
                  end else begin
                     nx.wpend = 1'b1;
                     nx.wdata = {st.addr, rx_byte};
                  end
                  nx.addr = st.addr + 1'b1;
                  nx.dirty = 1'b1;
               end
               // The next byte is fetched while this one shifts out.
               PH_RDATA: begin
                  nx.addr = st.addr + 1'b1;
                  nx.mem_rd = 1'b1;
               end
               PH_STATUS_W: begin
                  nx.prot = {rx_byte[ST_WP_PIN_ENABLE_BIT], rx_byte[ST_BP1],
                     rx_byte[ST_BP0]};
                  nx.dc = rx_byte[ST_WP_PIN_ENABLE_BIT-1:ST_DC_LO];
                  nx.phase = PH_DONE;
               end
               default: ;
            endcase
         end
      end else if (st.sel && sck_fall
            && (st.phase == PH_RDATA || st.phase == PH_STATUS_R)) begin
         if (st.out_cnt == 3'h0) begin
            nx.so = (st.phase == PH_STATUS_R) ? status[7] : st.rdata[7];
            nx.tx = (st.phase == PH_STATUS_R) ? {status[6:0], 1'b0}
               : {st.rdata[6:0], 1'b0};
         end else begin
            nx.so = st.tx[7];
            nx.tx = {st.tx[6:0], 1'b0};
         end
         nx.out_cnt = st.out_cnt + 3'h1;
         nx.out_on = 1'b1;
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         st <= ST_RST;
      end else begin
         st <= nx;
      end
   end

   // The busy pin is open drain: it only ever pulls low.
   assign hw_store_busy_pin_o = 1'b0;
   assign hw_store_busy_pin_oe_o = busy;
   assign so_o = st.so;
   // SO driven only in output phases
   assign so_oe_o = st.sel && st.out_on;
   assign mem_addr_o = st.addr;
   assign mem_rd_o = st.mem_rd;
   assign wq.push_valid = st.wpend;
   assign wq.push_data = st.wdata;
   assign wq.pop_ready = wr_ready_i;
   assign wr_valid_o = wq.pop_valid;
   assign wr_addr_o = wq.pop_data[WW-1:8];
   assign wr_data_o = wq.pop_data[7:0];
   assign store_req_o = st.store_req;
   assign recall_req_o = st.recall_req;
   assign status_o = status;
   assign auto_save_en_o = st.autosave;
   assign spi_mode3_o = st.mode3;
   // standby waits for store or recall
   assign standby_o = !st.sel && !busy;
   assign write_overrun_o = st.overrun;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   sequence s_select;
      cs_fall && st.pw == PW_RUN && st.pg2;
   endsequence
   sequence s_opcode_done;
      st.sel && sck_rise && st.bit_cnt == 3'h7 && st.phase == PH_OPCODE
         && !cs_fall && !cs_rise && st.pg2;
   endsequence
   sequence s_release;
      cs_rise && st.sel && st.pw == PW_RUN;
   endsequence

   a_mode_pick: assert property (s_select |=>
      st.sel && st.mode3 == $past(st.sck2))
      else $error("Mode not taken from SCK at select");
   a_select_edge: assert property ($rose(st.sel) |->
      $past(cs_fall))
      else $error("Selected without a CS falling edge");
   a_ignore_quiet: assert property (st.phase == PH_IGNORE |->
      !so_oe_o ##1 (!so_oe_o || st.phase != PH_IGNORE))
      else $error("SO driven after invalid opcode");
   a_so_on_fall: assert property ($changed(so_o) |->
      $past(sck_fall))
      else $error("SO changed off a falling edge");
   a_recall_busy: assert property (st.pw == PW_RECALL |->
      hw_store_busy_pin_oe_o && !st.sel && status_o[ST_RDY])
      else $error("Power-up recall not shown busy");
   a_write_gate: assert property (s_opcode_done ##0
      (rx_byte == OP_WRITE && !st.wen) |=> st.phase == PH_IGNORE)
      else $error("Write accepted without latch");
   a_latch_set: assert property (s_release ##0
      (st.phase == PH_DONE && st.opc == OP_SET_WL) |=> st.wen)
      else $error("Set latch command lost");
   a_addr_done: assert property (st.sel && sck_rise
      && st.bit_cnt == 3'h7 && st.phase == PH_ADDR
      && st.byte_cnt == LAST_ADDR_BYTE && !cs_fall && !cs_rise
      && st.pg2 |=>
      st.mem_rd == st.rd_mode && st.phase != PH_ADDR)
      else $error("Address phase not closed after three bytes");
   a_power_stop: assert property ($fell(st.pg2) && st.pw == PW_RUN
      |=> !st.sel && st.pw == PW_DRAIN ##1 !st.sel)
      else $error("Still selected after supply loss");
   a_dirty_store: assert property (st.pw == PW_DRAIN
      && st.timer == 16'h0 |=>
      st.store_req == ($past(st.autosave) && $past(st.dirty))
      && st.pw == PW_OFF)
      else $error("Power-down store decision wrong");
endmodule

// File: dv/spi_master_model.sv
`timescale 1ns/100ps
// Behavioural bus master; SCK stands at the mode level outside frames.
module spi_master_model (
   output logic cs_n_o,
   output logic sck_o,
   output logic si_o,
   input wire logic so_i,
   input wire logic so_oe_i
);
   localparam realtime H = 62.5;

   // Deselected and quiet at time zero.
   initial begin
      cs_n_o = 1'b1;
      sck_o = 1'b0;
      si_o = 1'b0;
   end

   // msb first, one command per select.
   task automatic frame(input bit m3, input logic [7:0] tx[$],
                        output logic [7:0] rx[$], output bit oe);
      logic [7:0] b;
      rx = {};
      oe = 1'b0;
      sck_o = m3;
      // The extra nanosecond keeps link edges off system clock edges.
      #(2*H + 1.0) cs_n_o = 1'b0;
      foreach (tx[i]) begin
         for (int k = 7; k >= 0; k--) begin
            #H sck_o = 1'b0;
            si_o = tx[i][k];
            #H sck_o = 1'b1;
            // An undriven SO reads as the inverse, so it cannot pass.
            b[k] = so_oe_i ? so_i : ~so_i;
            oe |= so_oe_i;
         end
         rx.push_back(b);
      end
      #H sck_o = m3;
      #H cs_n_o = 1'b1;
      // The released data line shows the inverse of its last bit.
      si_o = ~si_o;
      #(2*H);
   endtask
endmodule

// File: dv/tb.sv
`timescale 1ns/100ps
module tb;
   import nvs_spi_pkg::*;
   localparam int RC = 20;
   localparam int FC = 10;
   logic clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic cs_n, sck, si, so_o, so_oe_o, hsb_oe, hsb_o;
   logic hsb_ext = 1'b0;
   logic power_good_i = 1'b1;
   logic wr_ready_i = 1'b0;
   logic [ADDR_BITS-1:0] mem_addr_o, wr_addr_o;
   logic mem_rd_o, wr_valid_o, store_req_o, recall_req_o;
   logic [7:0] wr_data_o, status_o, st_exp, d;
   logic auto_save_en_o, spi_mode3_o, standby_o, write_overrun_o;
   logic [2:0] nv_prot_i = 3'h0;
   logic [3:0] busy_cnt = 4'h0;
   logic [16:0] base;
   int miscompares = 0, check_count = 0, cycles = 0;
   int stores = 0, recalls = 0, reads = 0;
   logic [24:0] pops[$];
   logic [7:0] tx[$], rx[$];
   logic [7:0] bad[4] = '{8'h1e, 8'h00, 8'hff, 8'h07};
   bit oe;
   // Open-drain busy pin with pull-up; device or bench may pull it low.
   wire logic hsb_pin = ~((hsb_oe & ~hsb_o) | hsb_ext);
   wire logic nv_busy_i = (busy_cnt != 4'h0);
   wire logic [7:0] mem_rdata_i = mem_byte(mem_addr_o);

   always #5 clk_i = ~clk_i;

   nvsram_spi_slave_frontend #(.RECALL_CNT(RC), .FINISH_CNT(FC),
      .FIFO_WORDS(FIFO_DEPTH)) DUT (
      .clk_i(clk_i), .reset_i(reset_i), .cs_n_i(cs_n), .sck_i(sck),
      .si_i(si), .so_o(so_o), .so_oe_o(so_oe_o),
      .hw_store_busy_pin_i(hsb_pin), .hw_store_busy_pin_o(hsb_o),
      .hw_store_busy_pin_oe_o(hsb_oe), .power_good_i(power_good_i),
      .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o),
      .mem_rdata_i(mem_rdata_i), .wr_valid_o(wr_valid_o),
      .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o),
      .wr_ready_i(wr_ready_i), .store_req_o(store_req_o),
      .recall_req_o(recall_req_o), .nv_busy_i(nv_busy_i),
      .nv_prot_i(nv_prot_i), .status_o(status_o),
      .auto_save_en_o(auto_save_en_o), .spi_mode3_o(spi_mode3_o),
      .standby_o(standby_o), .write_overrun_o(write_overrun_o));

   spi_master_model master (.cs_n_o(cs_n), .sck_o(sck), .si_o(si),
      .so_i(so_o), .so_oe_i(so_oe_o));

   // Array contents mix high address bits in, so address slips show.
   function automatic logic [7:0] mem_byte(input logic [16:0] a);
      return a[7:0] ^ a[15:8] ^ {7'h0, a[16]};
   endfunction

   // Core model: counts requests, stays busy eight cycles, pops queue.
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (store_req_o === 1'b1)
         stores <= stores + 1;
      if (recall_req_o === 1'b1)
         recalls <= recalls + 1;
      if (mem_rd_o === 1'b1)
         reads <= reads + 1;
      if ((store_req_o | recall_req_o) === 1'b1)
         busy_cnt <= 4'h8;
      else if (busy_cnt != 4'h0)
         busy_cnt <= busy_cnt - 4'h1;
      if ((wr_valid_o & wr_ready_i) === 1'b1)
         pops.push_back({wr_addr_o, wr_data_o});
      if (cycles == 30000) begin
         miscompares++;
         give_verdict();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // One frame, then time for the command to act after deselect.
   task automatic run(input bit m3, input logic [7:0] q[$]);
      master.frame(m3, q, rx, oe);
      repeat (4) @(negedge clk_i);
   endtask

   // Latch set first, since write-type commands are refused without it.
   task automatic cmd(input logic [7:0] q[$]);
      run(1'b0, {OP_SET_WL});
      run(1'b1, q);
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      void'($urandom(32'ha14186e5));
      nv_prot_i = 3'($urandom);
      repeat (12) @(negedge clk_i);
      reset_i = 1'b0;
      check(status_o, 8'h01);
      check({hsb_pin, hsb_oe, standby_o}, 3'b010);
      repeat (RC + 30) @(negedge clk_i);
      st_exp = {nv_prot_i[2], 3'h0, nv_prot_i[1:0], 2'h0};
      check({hsb_pin, hsb_oe, standby_o, status_o}, {3'b101, st_exp});
      check(recalls, 1);
      $display("test reset done");
      // Status read in both modes; the reply repeats after one byte.
      for (int m = 0; m < 2; m++) begin
         run(1'(m), {OP_STATUS_R, 8'h00, 8'h00});
         check(spi_mode3_o, m);
         check({rx[1], rx[2], 7'h0, oe}, {st_exp, st_exp, 8'h01});
      end
      $display("test modes done");
      run(1'b0, {OP_SET_WL});
      check(status_o[ST_WEN], 1);
      run(1'b1, {OP_CLR_WL});
      check(status_o[ST_WEN], 0);
      run(1'b0, {OP_AUTO_OFF});
      check(auto_save_en_o, 1);
      cmd({OP_AUTO_OFF});
      check({auto_save_en_o, status_o[ST_WEN]}, 0);
      cmd({OP_AUTO_ON});
      check(auto_save_en_o, 1);
      d = 8'($urandom);
      cmd({OP_STATUS_W, d});
      st_exp = {d[7:2], 2'h0};
      check(status_o, st_exp);
      $display("test commands done");
      run(1'b0, {OP_STORE});
      check(stores, 0);
      cmd({OP_STORE});
      check(stores, 1);
      cmd({OP_RECALL});
      check(recalls, 2);
      repeat (20) @(negedge clk_i);
      st_exp = {nv_prot_i[2], st_exp[6:4], nv_prot_i[1:0], 2'h0};
      check(status_o, st_exp);
      $display("test store recall done");
      foreach (bad[i]) begin
         run(1'(i), {bad[i], OP_SET_WL, OP_STATUS_R, 8'h00});
         check({oe, status_o[ST_WEN]}, 0);
      end
      run(1'b0, {OP_WRITE, 8'h00, 8'h00, 8'h00, 8'h55});
      check(wr_valid_o, 0);
      $display("test refusals done");
      // Queue plus pending word hold seventeen; the eighteenth is lost.
      base = 17'h1fff8;
      d = {7'($urandom), base[16]};
      tx = {OP_WRITE, d, base[15:8], base[7:0]};
      for (int i = 0; i <= FIFO_DEPTH + 1; i++)
         tx.push_back(8'($urandom));
      cmd(tx);
      check({wr_valid_o, write_overrun_o}, 2'b11);
      repeat (300) @(negedge clk_i) wr_ready_i = 1'($urandom);
      check({wr_valid_o, 31'(pops.size())}, FIFO_DEPTH + 1);
      foreach (pops[i])
         check(pops[i], {17'(base + 17'(i)), tx[4+i]});
      $display("test write done");
      base = 17'($urandom);
      d = {7'h0, base[16]};
      run(1'b1, {OP_READ, d, base[15:8], base[7:0], 8'h00, 8'h00});
      check({rx[4], rx[5]}, {mem_byte(base), mem_byte(base + 17'h1)});
      check(reads, 3);
      $display("test read done");
      // An outside low on the busy pin stores the written array.
      hsb_ext = 1'b1;
      repeat (20) @(negedge clk_i);
      hsb_ext = 1'b0;
      check(stores, 2);
      $display("test busy pin done");
      // Power loss with a dirty array stores; a clean one does not.
      for (int p = 0; p < 2; p++) begin
         power_good_i = 1'b0;
         repeat (FC + 30) @(negedge clk_i);
         check(stores, 3);
         power_good_i = 1'b1;
         repeat (RC + 30) @(negedge clk_i);
         check({recalls[30:0], standby_o}, {31'(3 + p), 1'b1});
      end
      $display("test power done");
      give_verdict();
   end
endmodule
